// file: rtl/swbc_ctrl.sv
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module swbc_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [swbc_pkg::AXI_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [swbc_pkg::AXI_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	swbc_link_if.ctrl link
);
	typedef enum logic [1:0] {C_IDLE, C_LAT, C_DATA} swbc_cst_t;

	// ==========================================================
	// AXI4-Lite slave
	logic aw_got;
	logic w_got;
	logic [7:0] aw_a;
	logic [31:0] w_d;
	logic [3:0] w_s;
	logic [31:0] ctrl_q;
	logic [31:0] mask_q;
	logic [31:0] twr_q;
	logic [31:0] data_q [4];
	logic refused;
	logic pend;
	swbc_cst_t st;

	wire aw_hs = awvalid && awready;
	wire w_hs = wvalid && wready;
	wire ar_hs = arvalid && arready;
	wire do_wr = aw_got && w_got && !bvalid;
	wire next_aw_got = (aw_got || aw_hs) && !do_wr;
	wire next_w_got = (w_got || w_hs) && !do_wr;
	wire next_rvalid = ar_hs || (rvalid && !rready);
	wire w_ctrl = aw_a == swbc_pkg::REG_CTRL;
	wire w_cmd = aw_a == swbc_pkg::REG_CMD;
	wire w_mask = aw_a == swbc_pkg::REG_MASK;
	wire w_stat = aw_a == swbc_pkg::REG_STATUS;
	wire w_twr = aw_a == swbc_pkg::REG_TWR;
	wire w_data = aw_a[7:4] == swbc_pkg::REG_DATA_HI;
	wire w_map = w_ctrl || w_cmd || w_mask || w_stat || w_twr || w_data;
	wire busy = pend || st != C_IDLE;
	wire r_data = araddr[7:4] == swbc_pkg::REG_DATA_HI;
	wire r_map = r_data || araddr == swbc_pkg::REG_CTRL ||
		araddr == swbc_pkg::REG_CMD || araddr == swbc_pkg::REG_MASK ||
		araddr == swbc_pkg::REG_STATUS || araddr == swbc_pkg::REG_TWR;
	wire [31:0] stat_v = 32'({refused, busy});
	wire [31:0] rd_val = r_data ? data_q[araddr[3:2]] :
		araddr == swbc_pkg::REG_CTRL ? ctrl_q :
		araddr == swbc_pkg::REG_MASK ? mask_q :
		araddr == swbc_pkg::REG_STATUS ? stat_v :
		araddr == swbc_pkg::REG_TWR ? twr_q : 32'h0000_0000;

	function automatic logic [31:0] strb_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		strb_merge = r;
	endfunction : strb_merge

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= swbc_pkg::RESP_OKAY;
			aw_a <= '0;
			w_d <= '0;
			w_s <= '0;
		end else if (ce) begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			awready <= !next_aw_got;
			wready <= !next_w_got;
			bvalid <= do_wr || (bvalid && !bready);
			if (do_wr) begin
				bresp <= w_map ? swbc_pkg::RESP_OKAY : swbc_pkg::RESP_SLVERR;
			end
			if (aw_hs) begin
				aw_a <= awaddr;
			end
			if (w_hs) begin
				w_d <= wdata;
				w_s <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= swbc_pkg::RESP_OKAY;
		end else if (ce) begin
			arready <= !next_rvalid;
			rvalid <= next_rvalid;
			if (ar_hs) begin
				rdata <= rd_val;
				rresp <= r_map ? swbc_pkg::RESP_OKAY : swbc_pkg::RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// Command legality
	logic [15:0] mrs_q;
	logic [8:0] cmd_q;
	logic [9:0] since_wr;
	wire [1:0] n_op = w_d[swbc_pkg::CMD_OP +: 2];
	wire m_fix4 = mrs_q[swbc_pkg::CTRL_BL +: 2] == swbc_pkg::BL_FIX4;
	wire m_pre2 = mrs_q[swbc_pkg::CTRL_PRE2];
	wire [swbc_pkg::LAT_W-1:0] m_wl =
		swbc_pkg::LAT_W'(mrs_q[swbc_pkg::CTRL_AL +: 5]) +
		swbc_pkg::LAT_W'(mrs_q[swbc_pkg::CTRL_CWL +: 5]);
	wire cfg_bad = (ctrl_q[swbc_pkg::CTRL_DM] && ctrl_q[swbc_pkg::CTRL_DBI]) ||
		(ctrl_q[swbc_pkg::CTRL_PRE2] &&
		ctrl_q[swbc_pkg::CTRL_CWL +: 5] <= swbc_pkg::CWL_MIN);
	wire [9:0] col_gap = m_pre2 ? swbc_pkg::GAP_PRE2 :
		swbc_pkg::GAP_PRE1;
	wire [9:0] pre_gap = 10'(m_wl) + (m_fix4 ? swbc_pkg::PRE_EXTRA_FIX4 :
		swbc_pkg::PRE_EXTRA_OTF) + twr_q[9:0];
	wire legal = n_op == swbc_pkg::OP_MRS ? !cfg_bad :
		n_op == swbc_pkg::OP_WR ? since_wr >= col_gap :
		n_op == swbc_pkg::OP_PRE ? since_wr >= pre_gap : 1'b1;
	wire cmd_req = do_wr && w_cmd;
	wire refuse = cmd_req && (busy || !legal);
	wire stat_clr = do_wr && w_stat && w_s[0] && w_d[swbc_pkg::STAT_REFUSED];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= swbc_pkg::CTRL_RESET;
			mask_q <= '0;
			twr_q <= swbc_pkg::TWR_RESET;
			for (int i = 0; i < 4; i++) begin
				data_q[i] <= '0;
			end
		end else if (ce && do_wr) begin
			if (w_ctrl) ctrl_q <= strb_merge(ctrl_q, w_d, w_s);
			if (w_mask) mask_q <= strb_merge(mask_q, w_d, w_s);
			if (w_twr) twr_q <= strb_merge(twr_q, w_d, w_s);
			if (w_data) data_q[aw_a[3:2]] <= strb_merge(data_q[aw_a[3:2]], w_d, w_s);
		end
	end

	// ==========================================================
	// Link side: clock divided by two, outputs change as it falls, reset_n as it rises
	logic [3:0] rst_cnt;
	logic [swbc_pkg::LAT_W-1:0] cnt;
	logic [2:0] pair;
	logic chop_q;
	wire tick = ce && link.ck;
	wire issue = tick && pend && link.reset_n;
	wire [1:0] c_op = cmd_q[swbc_pkg::CMD_OP +: 2];
	wire c_chop = swbc_pkg::is_chop(mrs_q[swbc_pkg::CTRL_BL +: 2],
		cmd_q[swbc_pkg::CMD_A12]);
	wire more = pair <= {1'b0, swbc_pkg::last_pair(chop_q)};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.ck <= 1'b0;
			link.reset_n <= 1'b0;
			rst_cnt <= '0;
			pend <= 1'b0;
			refused <= 1'b0;
			cmd_q <= '0;
			since_wr <= swbc_pkg::SINCE_MAX;
		end else if (ce) begin
			link.ck <= !link.ck;
			if (tick && rst_cnt != swbc_pkg::RST_TICKS) rst_cnt <= rst_cnt + 4'h1;
			link.reset_n <= rst_cnt == swbc_pkg::RST_TICKS;
			refused <= refuse || (refused && !stat_clr);
			if (cmd_req && !refuse) begin
				pend <= 1'b1;
				cmd_q <= w_d[8:0];
			end else if (issue) begin
				pend <= 1'b0;
			end
			if (issue && c_op == swbc_pkg::OP_WR) since_wr <= '0;
			else if (tick && since_wr != swbc_pkg::SINCE_MAX) since_wr <= since_wr + 10'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.cmd_valid <= 1'b0;
			link.cmd_op <= swbc_pkg::OP_MRS;
			link.bank <= '0;
			link.col <= '0;
			link.a10 <= 1'b0;
			link.a12 <= 1'b0;
			mrs_q <= swbc_pkg::CTRL_RESET[15:0];
		end else if (tick) begin
			link.cmd_valid <= issue;
			if (issue) begin
				link.cmd_op <= c_op;
				link.bank <= cmd_q[swbc_pkg::CMD_BANK +: swbc_pkg::BANK_W];
				link.col <= cmd_q[swbc_pkg::CMD_COL +: swbc_pkg::COL_W];
				link.a10 <= cmd_q[swbc_pkg::CMD_A10];
				link.a12 <= cmd_q[swbc_pkg::CMD_A12];
				if (c_op == swbc_pkg::OP_MRS) mrs_q <= ctrl_q[15:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.burst_length_select_field <= swbc_pkg::BL_FIX8;
			{link.dm_en, link.dbi_en, link.crc_en, link.pre2} <= '0;
			link.al <= '0;
			link.cwl <= swbc_pkg::CWL_MIN;
		end else if (tick) begin
			link.burst_length_select_field <= ctrl_q[swbc_pkg::CTRL_BL +: 2];
			link.dm_en <= ctrl_q[swbc_pkg::CTRL_DM];
			link.dbi_en <= ctrl_q[swbc_pkg::CTRL_DBI];
			link.crc_en <= ctrl_q[swbc_pkg::CTRL_CRC];
			link.pre2 <= ctrl_q[swbc_pkg::CTRL_PRE2];
			link.al <= ctrl_q[swbc_pkg::CTRL_AL +: 5];
			link.cwl <= ctrl_q[swbc_pkg::CTRL_CWL +: 5];
		end
	end

	// Data for pair p is beats 2p and 2p+1; a set mask bit masks a lane.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= C_IDLE;
			cnt <= '0;
			pair <= '0;
			chop_q <= 1'b0;
			link.dqs_valid <= 1'b0;
			link.dq <= '0;
			link.dm_n <= '1;
		end else if (tick) begin
			case (st)
				C_IDLE: begin
					if (issue && c_op == swbc_pkg::OP_WR) begin
						st <= C_LAT;
						cnt <= m_wl - swbc_pkg::LAT_W'(1);
						chop_q <= c_chop;
						pair <= '0;
					end
				end
				C_LAT, C_DATA: begin
					if (st == C_LAT && cnt != '0) begin
						cnt <= cnt - swbc_pkg::LAT_W'(1);
					end else if (more) begin
						st <= C_DATA;
						link.dqs_valid <= 1'b1;
						link.dq <= data_q[pair[1:0]];
						link.dm_n <= ~mask_q[pair[1:0]*4 +: 4];
						pair <= pair + 3'h1;
					end else begin
						st <= C_IDLE;
						link.dqs_valid <= 1'b0;
						link.dm_n <= '1;
					end
				end
				default: st <= C_IDLE;
			endcase
		end
	end
endmodule : swbc_ctrl

// file: include/swbc_pkg.sv
package swbc_pkg;
	// ==========================================================
	// Widths
	localparam int DW = 16;
	localparam int LANES = DW / 8;
	localparam int BANK_W = 2;
	localparam int NBANK = 1 << BANK_W;
	localparam int COL_W = 3;
	localparam int PAIR_W = 2;
	localparam int MEM_AW = BANK_W + COL_W + PAIR_W + 1;
	localparam int LAT_W = 6;
	localparam int LAT_DEPTH = 1 << LAT_W;
	localparam int AXI_AW = 8;
	localparam int ORG_NO_MASK = 4;
	// ==========================================================
	// Link encodings
	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;
	localparam logic [1:0] OP_MRS = 2'h0;
	localparam logic [1:0] OP_ACT = 2'h1;
	localparam logic [1:0] OP_WR = 2'h2;
	localparam logic [1:0] OP_PRE = 2'h3;
	localparam logic [1:0] CRC_OFF = 2'h0;
	localparam logic [1:0] CRC_NONPERSIST = 2'h1;
	localparam logic [1:0] CRC_PERSIST = 2'h2;
	localparam logic [PAIR_W-1:0] LAST_PAIR_BL8 = 2'h3;
	localparam logic [PAIR_W-1:0] LAST_PAIR_BC4 = 2'h1;
	// ==========================================================
	// Timing in link clock cycles
	localparam logic [4:0] CWL_MIN = 5'h09;
	localparam logic [9:0] GAP_PRE1 = 10'h004;
	localparam logic [9:0] GAP_PRE2 = 10'h006;
	localparam logic [9:0] GAP_FORBID_PRE2 = 10'h005;
	localparam logic [9:0] PRE_EXTRA_OTF = 10'h004;
	localparam logic [9:0] PRE_EXTRA_FIX4 = 10'h002;
	localparam logic [9:0] SINCE_MAX = 10'h3FF;
	localparam logic [3:0] RST_TICKS = 4'h8;
	// ==========================================================
	// Controller registers
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_TWR = 8'h10;
	localparam logic [3:0] REG_DATA_HI = 4'h2;
	localparam int CTRL_BL = 0;
	localparam int CTRL_DM = 2;
	localparam int CTRL_DBI = 3;
	localparam int CTRL_CRC = 4;
	localparam int CTRL_PRE2 = 5;
	localparam int CTRL_AL = 6;
	localparam int CTRL_CWL = 11;
	localparam int CMD_OP = 0;
	localparam int CMD_BANK = 2;
	localparam int CMD_COL = 4;
	localparam int CMD_A10 = 7;
	localparam int CMD_A12 = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_REFUSED = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_4800;
	localparam logic [31:0] TWR_RESET = 32'h0000_000C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic is_chop(input logic [1:0] bls, input logic a12);
		is_chop = (bls == BL_FIX4) || (bls == BL_OTF && !a12);
	endfunction : is_chop

	function automatic logic [PAIR_W-1:0] last_pair(input logic chop);
		last_pair = chop ? LAST_PAIR_BC4 : LAST_PAIR_BL8;
	endfunction : last_pair
endpackage : swbc_pkg

// file: include/swbc_link_if.sv
`timescale 1ns/1ps
interface swbc_link_if;
	logic ck;
	logic reset_n;
	logic cmd_valid;
	logic [1:0] cmd_op;
	logic [swbc_pkg::BANK_W-1:0] bank;
	logic [swbc_pkg::COL_W-1:0] col;
	logic a10;
	logic a12;
	logic [1:0] burst_length_select_field;
	logic dm_en;
	logic dbi_en;
	logic crc_en;
	logic pre2;
	logic [4:0] al;
	logic [4:0] cwl;
	logic [2*swbc_pkg::DW-1:0] dq;
	logic [2*swbc_pkg::LANES-1:0] dm_n;
	logic dqs_valid;
	modport ctrl(output ck, reset_n, cmd_valid, cmd_op, bank, col, a10, a12,
		burst_length_select_field, dm_en, dbi_en, crc_en, pre2, al, cwl,
		dq, dm_n, dqs_valid);
	modport dram(input ck, reset_n, cmd_valid, cmd_op, bank, col, a10, a12,
		burst_length_select_field, dm_en, dbi_en, crc_en, pre2, al, cwl,
		dq, dm_n, dqs_valid);
endinterface : swbc_link_if

// file: rtl/swbc_lat_line.sv
`timescale 1ns/1ps
module swbc_lat_line #(
	parameter int W = 8,
	parameter int DEPTH = 64
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] din,
	input wire logic [$clog2(DEPTH)-1:0] tap,
	output logic [W-1:0] dout
);
	logic [W-1:0] sr [DEPTH];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				sr[i] <= '0;
			end
		end else if (ce) begin
			sr[0] <= din;
			for (int i = 1; i < DEPTH; i++) begin
				sr[i] <= sr[i-1];
			end
		end
	end

	// A fixed-length line with a moving tap lets commands overlap.
	assign dout = sr[tap];
endmodule : swbc_lat_line

// file: rtl/swbc_dram.sv
`timescale 1ns/1ps
// Functional notes
// - Writes accept BL8, fixed BC4, on-the-fly.
// - On-the-fly: a12 low chops, high eight.
// - a10 low: bank stays open after burst.
// - a10 high: bank precharges after burst.
// - Masking exists on x8 and x16 only.
// - Mask and bus inversion never together.
// - Mask input applies to writes only.
// - Mask low: beat discarded, array unchanged.
// - Mask high: beat written into array.
// - With CRC, mask enable picks persistent mode.
// - Data starts additive plus write CAS latency.
// - Two-cycle preamble forbids lowest write latency.
// - Two-cycle preamble forbids five-cycle column spacing.
// - Writes four cycles apart give seamless data.
// - Recovery counted from edge after last beat.
// - Field 00 fixed eight, 01 on-the-fly.
// - Field 10 forces chopped four-beat bursts.
// - Precharge waits latency, burst and recovery.
module swbc_dram #(
	parameter int ORG_WIDTH = 16
) (
	swbc_link_if.dram link,
	input wire logic ce,
	input wire logic [swbc_pkg::MEM_AW-1:0] peek_addr,
	output logic [swbc_pkg::DW-1:0] peek_data,
	output logic [swbc_pkg::NBANK-1:0] bank_open,
	output logic [1:0] crc_mode,
	output logic wr_ref_pulse,
	output logic ap_pulse,
	output logic cfg_err,
	output logic gap_err
);
	localparam int IW = 2 + swbc_pkg::BANK_W + swbc_pkg::COL_W;
	localparam int DW = swbc_pkg::DW;
	localparam int LN = swbc_pkg::LANES;

	// ==========================================================
	// Mode state, loaded by a mode-set command
	logic [1:0] bl_sel;
	logic dm_en;
	logic dbi_en;
	logic crc_en;
	logic pre2;
	logic [4:0] al;
	logic [4:0] cwl;
	logic [9:0] since_col;

	wire cmd_mrs = link.cmd_valid && link.cmd_op == swbc_pkg::OP_MRS;
	wire cmd_act = link.cmd_valid && link.cmd_op == swbc_pkg::OP_ACT;
	wire cmd_wr = link.cmd_valid && link.cmd_op == swbc_pkg::OP_WR;
	wire cmd_pre = link.cmd_valid && link.cmd_op == swbc_pkg::OP_PRE;
	wire mrs_bad = (link.dm_en && link.dbi_en) ||
		(link.pre2 && link.cwl <= swbc_pkg::CWL_MIN);
	wire gap_bad = cmd_wr && (since_col < swbc_pkg::GAP_PRE1 ||
		(pre2 && since_col == swbc_pkg::GAP_FORBID_PRE2));

	always_ff @(posedge link.ck) begin
		if (!link.reset_n) begin
			bl_sel <= swbc_pkg::BL_FIX8;
			dm_en <= 1'b0;
			dbi_en <= 1'b0;
			crc_en <= 1'b0;
			pre2 <= 1'b0;
			al <= '0;
			cwl <= swbc_pkg::CWL_MIN;
		end else if (ce && cmd_mrs) begin
			bl_sel <= link.burst_length_select_field;
			dm_en <= link.dm_en;
			dbi_en <= link.dbi_en;
			crc_en <= link.crc_en;
			pre2 <= link.pre2;
			al <= link.al;
			cwl <= link.cwl;
		end
	end

	// Spacing check only raises gap_err; the write still goes ahead.
	always_ff @(posedge link.ck) begin
		if (!link.reset_n) begin
			since_col <= swbc_pkg::SINCE_MAX;
			cfg_err <= 1'b0;
			gap_err <= 1'b0;
		end else if (ce) begin
			if (cmd_wr) begin
				since_col <= 10'h001;
			end else if (since_col != swbc_pkg::SINCE_MAX) begin
				since_col <= since_col + 10'h001;
			end
			cfg_err <= cfg_err || (cmd_mrs && mrs_bad);
			gap_err <= gap_err || gap_bad;
		end
	end

	// ==========================================================
	// Write latency line
	wire [swbc_pkg::LAT_W-1:0] wl = swbc_pkg::LAT_W'(al) +
		swbc_pkg::LAT_W'(cwl);
	wire [swbc_pkg::LAT_W-1:0] tap = wl - swbc_pkg::LAT_W'(1);
	wire chop_now = swbc_pkg::is_chop(bl_sel, link.a12);
	wire [IW:0] dl_in = {cmd_wr, chop_now, link.a10, link.bank, link.col};
	logic [IW:0] dl_out;

	swbc_lat_line #(
		.W(IW + 1),
		.DEPTH(swbc_pkg::LAT_DEPTH)
	) u_lat (
		.clk(link.ck),
		.rst_n(link.reset_n),
		.ce(ce),
		.din(dl_in),
		.tap(tap),
		.dout(dl_out)
	);

	// ==========================================================
	// Burst sequencing, two beats per link cycle
	logic act;
	logic [swbc_pkg::PAIR_W-1:0] pair;
	logic [IW-1:0] cur;

	wire start = dl_out[IW];
	wire [IW-1:0] winfo = start ? dl_out[IW-1:0] : cur;
	wire [swbc_pkg::PAIR_W-1:0] wp = start ? '0 : pair;
	wire w_chop = winfo[IW-1];
	wire w_ap = winfo[IW-2];
	wire [swbc_pkg::BANK_W-1:0] w_bank =
		winfo[swbc_pkg::COL_W +: swbc_pkg::BANK_W];
	wire [swbc_pkg::COL_W-1:0] w_col = winfo[swbc_pkg::COL_W-1:0];
	wire [swbc_pkg::PAIR_W-1:0] w_last = swbc_pkg::last_pair(w_chop);
	wire slot = start || act;
	wire wen = slot && wp <= w_last;
	wire data_last = slot && wp == w_last;

	// A new start takes over the slot of a burst just ending.
	always_ff @(posedge link.ck) begin
		if (!link.reset_n) begin
			act <= 1'b0;
			pair <= '0;
			cur <= '0;
		end else if (ce) begin
			if (start) begin
				act <= 1'b1;
				pair <= swbc_pkg::PAIR_W'(1);
				cur <= dl_out[IW-1:0];
			end else if (act) begin
				pair <= pair + swbc_pkg::PAIR_W'(1);
				if (pair == swbc_pkg::LAST_PAIR_BL8) begin
					act <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Array with per-lane masking or inversion
	logic [DW-1:0] mem [1 << swbc_pkg::MEM_AW];

	wire dm_live = dm_en && !dbi_en && ORG_WIDTH != swbc_pkg::ORG_NO_MASK;
	wire dbi_live = dbi_en && !dm_en;

	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
		input logic [DW-1:0] din, input logic [LN-1:0] dmn,
		input logic dm, input logic dbi);
		logic [DW-1:0] r;
		r = din;
		for (int l = 0; l < LN; l++) begin
			if (dbi && !dmn[l]) begin
				r[l*8 +: 8] = ~din[l*8 +: 8];
			end else if (dm && !dmn[l]) begin
				r[l*8 +: 8] = old[l*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// Mask pin is read only in write data slots.
	always_ff @(posedge link.ck) begin
		if (ce && wen) begin
			for (int h = 0; h < 2; h++) begin
				mem[{w_bank, w_col, wp, 1'(h)}] <= merge(
					mem[{w_bank, w_col, wp, 1'(h)}],
					link.dq[h*DW +: DW], link.dm_n[h*LN +: LN],
					dm_live, dbi_live);
			end
		end
	end

	// ==========================================================
	// Bank state and status outputs
	function automatic logic [swbc_pkg::NBANK-1:0] onehot(
		input logic [swbc_pkg::BANK_W-1:0] b);
		onehot = swbc_pkg::NBANK'(1) << b;
	endfunction : onehot

	wire [swbc_pkg::NBANK-1:0] act_set = cmd_act ? onehot(link.bank) : '0;
	wire [swbc_pkg::NBANK-1:0] pre_clr = cmd_pre ? onehot(link.bank) : '0;
	wire [swbc_pkg::NBANK-1:0] ap_clr =
		(data_last && w_ap) ? onehot(w_bank) : '0;
	wire [swbc_pkg::NBANK-1:0] next_bank_open =
		(bank_open & ~pre_clr & ~ap_clr) | act_set;
	wire [1:0] next_crc_mode = !crc_en ? swbc_pkg::CRC_OFF :
		dm_en ? swbc_pkg::CRC_PERSIST :
		swbc_pkg::CRC_NONPERSIST;

	always_ff @(posedge link.ck) begin
		if (!link.reset_n) begin
			bank_open <= '0;
			crc_mode <= swbc_pkg::CRC_OFF;
			wr_ref_pulse <= 1'b0;
			ap_pulse <= 1'b0;
			peek_data <= '0;
		end else if (ce) begin
			bank_open <= next_bank_open;
			crc_mode <= next_crc_mode;
			wr_ref_pulse <= data_last;
			ap_pulse <= data_last && w_ap;
			peek_data <= mem[peek_addr];
		end
	end
endmodule : swbc_dram

// file: tb/swbc_sva.sv
`timescale 1ns/1ps
module swbc_sva (
	input wire logic ck,
	input wire logic reset_n,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic a12,
	input wire logic dm_en,
	input wire logic dbi_en,
	input wire logic pre2,
	input wire logic [4:0] al,
	input wire logic [4:0] cwl,
	input wire logic dqs_valid
);
	// ==========================================================
	// Write history, so latency checks follow the last mode-set.
	logic [63:0] hist;
	logic [5:0] wl;
	logic [9:0] since;
	wire wr = cmd_valid && cmd_op == swbc_pkg::OP_WR;
	wire mrs = cmd_valid && cmd_op == swbc_pkg::OP_MRS;
	wire pre = cmd_valid && cmd_op == swbc_pkg::OP_PRE;
	wire [9:0] pre_min = {4'h0, wl} + swbc_pkg::PRE_EXTRA_FIX4;
	always_ff @(posedge ck) begin
		if (!reset_n) begin
			hist <= '0;
			wl <= 6'(swbc_pkg::CWL_MIN);
			since <= swbc_pkg::SINCE_MAX;
		end else begin
			hist <= {hist[62:0], wr};
			if (mrs) begin
				wl <= {1'b0, al} + {1'b0, cwl};
			end
			if (wr) begin
				since <= 10'h001;
			end else if (since != swbc_pkg::SINCE_MAX) begin
				since <= since + 10'h001;
			end
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge ck); endclocking
	default disable iff (!reset_n);
	property p_gap4; wr |=> !wr [*3]; endproperty
	a_gap4: assert property (p_gap4) else $error("write gap short");
	property p_gap5; wr && pre2 |-> ##5 !wr; endproperty
	a_gap5: assert property (p_gap5) else $error("five gap");
	property p_mask_dbi; mrs |-> !(dm_en && dbi_en); endproperty
	a_mask_dbi: assert property (p_mask_dbi) else $error("dm dbi");
	property p_cwl; mrs && pre2 |-> cwl > swbc_pkg::CWL_MIN; endproperty
	a_cwl: assert property (p_cwl) else $error("cwl too low");
	property p_start; $rose(dqs_valid) |-> hist[wl-6'h01]; endproperty
	a_start: assert property (p_start) else $error("data early");
	property p_due; hist[wl-6'h01] |-> dqs_valid ##1 dqs_valid; endproperty
	a_due: assert property (p_due) else $error("data missing");
	property p_win;
		dqs_valid |-> hist[wl-6'h01] || hist[wl] || hist[wl+6'h01]
			|| hist[wl+6'h02];
	endproperty
	a_win: assert property (p_win) else $error("stray data");
	property p_pre; pre |-> since >= pre_min; endproperty
	a_pre: assert property (p_pre) else $error("early precharge");
	c_bl8: cover property (wr && a12);
	c_chop: cover property (wr && !a12);
	c_pre2: cover property (wr && pre2);
	c_prech: cover property (pre);
endmodule : swbc_sva

// file: tb/sdram_write_burst_control_tb.sv
`timescale 1ns/1ps
module sdram_write_burst_control_tb;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic arvalid = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic ap_pulse, wr_ref_pulse, cfg_err, gap_err, a10, a12, dm, p2, chop;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, peek_addr = 8'h00, ad;
	logic [31:0] wdata = 32'h0, rdata, rv, mk, nd[4];
	logic [1:0] bresp, rresp, rsp, crc_mode, bls, bk, m2;
	logic [2:0] col;
	logic [3:0] bank_open;
	logic [4:0] al;
	logic [15:0] peek_data, nw, ex, mdl[256];
	bit known[256];
	int fails, samples_checked, cyc, n_wr, n_ap, n_ref, n_apx, seed, i, k;
	swbc_link_if link();
	swbc_ctrl swbc_ctrl_inst (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid,
		.awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
		.bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready(1'b1), .link(link.ctrl));
	swbc_dram swbc_dram_inst (.link(link.dram), .ce(1'b1), .peek_addr,
		.peek_data, .bank_open, .crc_mode, .wr_ref_pulse, .ap_pulse, .cfg_err,
		.gap_err);
	swbc_sva swbc_sva_inst (.ck(link.ck), .reset_n(link.reset_n),
		.cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .a12(link.a12),
		.dm_en(link.dm_en), .dbi_en(link.dbi_en), .pre2(link.pre2),
		.al(link.al), .cwl(link.cwl), .dqs_valid(link.dqs_valid));
	always #10 aclk = ~aclk;
	// Pulses are counted on the falling edge, away from their launch edge.
	always @(negedge link.ck) begin
		n_ref += wr_ref_pulse;
		n_ap += ap_pulse;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			give_verdict();
		end
	end
	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			if (awready) pa = 1'b0;
			if (wready) pw = 1'b0;
			@(posedge aclk);
			awvalid <= pa;
			wvalid <= pw;
		end
		do @(negedge aclk); while (!bvalid);
		rsp = bresp;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		rv = rdata;
		rsp = rresp;
		@(posedge aclk);
	endtask : rd
	// Busy covers the burst in flight, so polling it waits out the data.
	task automatic cmd(input logic [31:0] w);
		wr(swbc_pkg::REG_CMD, w);
		do begin
			repeat (4) @(posedge aclk);
			rd(swbc_pkg::REG_STATUS);
		end while (rv[swbc_pkg::STAT_BUSY] !== 1'b0);
		repeat (8) @(posedge aclk);
	endtask : cmd
	task automatic give_verdict();
		$display("checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	// ==========================================================
	// Main sequence
	initial begin
		seed = 95151;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(swbc_pkg::REG_CTRL);
		chk(rv, swbc_pkg::CTRL_RESET);
		chk(rsp, swbc_pkg::RESP_OKAY);
		rd(swbc_pkg::REG_TWR);
		chk(rv, swbc_pkg::TWR_RESET);
		wr(8'h40, 32'h0);
		chk(rsp, swbc_pkg::RESP_SLVERR);
		for (i = 0; i < 8; i++) begin
			bls = (i % 4 == 3) ? swbc_pkg::BL_FIX4 :
				(i % 4 == 0) ? swbc_pkg::BL_FIX8 : swbc_pkg::BL_OTF;
			a12 = (i % 4 == 1) || (i % 4 != 2 && $random(seed) % 2 != 0);
			dm = i >= 4;
			p2 = i == 2;
			a10 = 1'($random(seed));
			bk = 2'($random(seed));
			col = 3'($random(seed));
			al = 5'({$random(seed)} % 4);
			wr(swbc_pkg::REG_CTRL, 32'(bls) | 32'(dm) << 2 | 32'(p2) << 5
				| 32'(al) << 6 | 32'(5'h09 + 5'(p2)) << 11);
			cmd(32'(swbc_pkg::OP_MRS));
			cmd(32'(swbc_pkg::OP_ACT) | 32'(bk) << 2);
			mk = dm ? $random(seed) : 32'h0;
			wr(swbc_pkg::REG_MASK, mk);
			for (k = 0; k < 4; k++) begin
				nd[k] = $random(seed);
				wr({swbc_pkg::REG_DATA_HI, 2'(k), 2'h0}, nd[k]);
			end
			cmd(32'(swbc_pkg::OP_WR) | 32'(bk) << 2 | 32'(col) << 4
				| 32'(a10) << 7 | 32'(a12) << 8);
			n_wr++;
			n_apx += a10;
			chk(bank_open[bk], !a10);
			chop = bls == swbc_pkg::BL_FIX4 || (bls == swbc_pkg::BL_OTF && !a12);
			for (k = 0; k < 8; k++) begin
				ad = {bk, col, 3'(k)};
				peek_addr <= ad;
				repeat (4) @(posedge aclk);
				nw = nd[k / 2][16 * (k % 2) +: 16];
				m2 = (chop && k >= 4) ? 2'h3 : mk[2 * k +: 2];
				ex = {m2[1] ? mdl[ad][15:8] : nw[15:8],
					m2[0] ? mdl[ad][7:0] : nw[7:0]};
				if (known[ad] || m2 == 2'h0) chk(peek_data, ex);
				mdl[ad] = ex;
				known[ad] = known[ad] || m2 == 2'h0;
			end
			$display("test burst %0d done", i);
		end
		for (k = 0; k < 4; k++) begin
			wr(swbc_pkg::REG_STATUS, 32'h2);
			wr(swbc_pkg::REG_CTRL, 32'h4800 | (k == 0 ? 32'hC : k == 1 ?
				32'h20 : k == 2 ? 32'h10 : 32'h14));
			cmd(32'(swbc_pkg::OP_MRS));
			rd(swbc_pkg::REG_STATUS);
			if (k < 2) chk(rv[swbc_pkg::STAT_REFUSED], 1'b1);
			if (k == 2) chk(crc_mode, swbc_pkg::CRC_NONPERSIST);
			if (k == 3) chk(crc_mode, swbc_pkg::CRC_PERSIST);
		end
		$display("test mode-set done");
		wr(swbc_pkg::REG_CTRL, 32'h4800);
		wr(swbc_pkg::REG_TWR, 32'h40);
		cmd(32'(swbc_pkg::OP_MRS));
		cmd(32'(swbc_pkg::OP_ACT));
		cmd(32'(swbc_pkg::OP_WR));
		n_wr++;
		wr(swbc_pkg::REG_STATUS, 32'h2);
		cmd(32'(swbc_pkg::OP_PRE));
		rd(swbc_pkg::REG_STATUS);
		chk(rv[swbc_pkg::STAT_REFUSED], 1'b1);
		chk(bank_open[0], 1'b1);
		repeat (200) @(posedge aclk);
		cmd(32'(swbc_pkg::OP_PRE));
		chk(bank_open[0], 1'b0);
		chk(n_ref, n_wr);
		chk(n_ap, n_apx);
		chk({cfg_err, gap_err}, 2'h0);
		$display("test precharge done");
		give_verdict();
	end
endmodule : sdram_write_burst_control_tb
